//--- rtl/spr_pkg.sv
// Package of register offsets, field positions and timing for the slot power register map
`default_nettype none
package spr_pkg;
	localparam logic [7:0] OFS_CONV_VALUE  = 8'h00;
	localparam logic [7:0] OFS_CONV_SETUP  = 8'h01;
	localparam logic [7:0] OFS_SLOT_A_CTRL = 8'h02;
	localparam logic [7:0] OFS_SLOT_B_CTRL = 8'h03;
	localparam logic [7:0] OFS_SLOT_A_COND = 8'h04;
	localparam logic [7:0] OFS_SLOT_B_COND = 8'h05;
	localparam logic [7:0] OFS_SHARED_COND = 8'h06;
	localparam logic [7:0] RST_SETUP       = 8'h00;
	localparam logic [7:0] RST_CTRL        = 8'h00;
	localparam int         SETUP_BUSY_BIT  = 7;
	localparam int         SETUP_SLOT_BIT  = 4;
	localparam int         SETUP_QTY_BIT   = 3;
	localparam logic [4:0] SETUP_WR_MASK   = 5'h1f;
	localparam int         CTRL_AUX_PG_BIT  = 7;
	localparam int         CTRL_MAIN_PG_BIT = 6;
	localparam int         CTRL_MAIN_EN_BIT = 1;
	localparam int         CTRL_AUX_EN_BIT  = 0;
	localparam logic [2:0] RAIL_NONE       = 3'h0;
	localparam logic [2:0] RAIL_MAX        = 3'h5;
	localparam logic [4:0] COND_FAULT_MASK = 5'h1f;
	localparam logic [3:0] ADDR_HI_BITS    = 4'h8;
	localparam logic [3:0] SCL_FILT_MAX    = 4'h0;
endpackage
`default_nettype wire

//--- rtl/spr_regs.sv
// SMBus byte-access register bank of a dual-slot power controller
`default_nettype none
module spr_regs
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       smb_clk,
	input  wire logic       smb_data_in,
	output logic            smb_data_out,
	output logic            smb_data_oe,
	input  wire logic       addr_strap_hi,
	input  wire logic       addr_strap_mid,
	input  wire logic       addr_strap_lo,
	output logic            conv_start,
	output logic      [4:0] conv_select,
	input  wire logic       conv_done,
	input  wire logic [7:0] conv_data,
	input  wire logic [3:0] power_good,
	input  wire logic [9:0] fault_event,
	input  wire logic [7:0] shared_status,
	output logic      [3:0] slot_enable,
	output logic            int_n
);
	// Link side: data is sampled on smb_clk rising edges, the frame state moves on falling ones
	typedef enum logic [2:0] {LS_IDLE, LS_ADDR, LS_CMD, LS_DATA, LS_ACK, LS_RD, LS_RACK} spr_ls_t;
	typedef struct packed {
		spr_ls_t    st;
		logic [2:0] bcnt;
		logic [7:0] shf;
		logic [7:0] cmd;
		logic       rd;
		logic [1:0] phase;
		logic       oe;
		logic       wr_tgl;
		logic [7:0] wr_cmd;
		logic [7:0] wr_dat;
		logic       sta_seen;
	} spr_link_t;
	spr_link_t l_q, l_d;

	typedef struct packed {
		logic       str_done;
		logic [2:0] straps;
		logic [1:0] tgl_s;
		logic       tgl_seen;
		logic [7:0] setup;
		logic [7:0] result;
		logic [3:0] en;
		logic [9:0] fault;
		logic       start;
		logic [1:0] str_cnt;
		logic [3:0] pg_s1;
		logic [3:0] pg_s2;
		logic [7:0] sh_s1;
		logic [7:0] sh_s2;
		logic [6:0][7:0] snap;
	} spr_core_t;
	spr_core_t c_q, c_d;

	logic [7:0] img_s1 [0:6];
	logic [7:0] img_s2 [0:6];
	logic [2:0] strap_s1, strap_s2;
	logic       sda_r;
	logic       sta_tgl;

	function automatic logic [7:0] reg_image(input spr_core_t c, input logic [7:0] ofs);
		case (ofs)
			spr_pkg::OFS_CONV_VALUE:  reg_image = c.result;
			spr_pkg::OFS_CONV_SETUP:  reg_image = {c.setup[7], 2'h0, c.setup[4:0]};
			spr_pkg::OFS_SLOT_A_CTRL: reg_image = {c.pg_s2[0], c.pg_s2[1], 4'h0, c.en[1:0]};
			spr_pkg::OFS_SLOT_B_CTRL: reg_image = {c.pg_s2[2], c.pg_s2[3], 4'h0, c.en[3:2]};
			spr_pkg::OFS_SLOT_A_COND: reg_image = {1'b0, c.en[1:0], c.fault[4:0]};
			spr_pkg::OFS_SLOT_B_COND: reg_image = {1'b0, c.en[3:2], c.fault[9:5]};
			spr_pkg::OFS_SHARED_COND: reg_image = c.sh_s2;
			default:                  reg_image = 8'h00;
		endcase
	endfunction

	// Core domain
	always_comb
	begin
		logic       wr;
		logic [2:0] rail;
		wr = c_q.tgl_s[1] ^ c_q.tgl_seen;
		rail = 3'h0;
		c_d = c_q;
		c_d.tgl_s = {c_q.tgl_s[0], l_q.wr_tgl};
		c_d.tgl_seen = c_q.tgl_s[1];
		c_d.start = 1'b0;
		c_d.pg_s1 = power_good;
		c_d.pg_s2 = c_q.pg_s1;
		c_d.sh_s1 = shared_status;
		c_d.sh_s2 = c_q.sh_s1;
		// The strap synchroniser needs two edges before its output is worth keeping
		if (!c_q.str_done)
		begin
			c_d.straps = strap_s2;
			c_d.str_cnt = c_q.str_cnt + 2'h1;
			c_d.str_done = (c_q.str_cnt == 2'h2);
		end
		c_d.fault = c_q.fault | fault_event;
		if (conv_done && c_q.setup[spr_pkg::SETUP_BUSY_BIT])
		begin
			c_d.result = conv_data;
			c_d.setup[spr_pkg::SETUP_BUSY_BIT] = 1'b0;
		end
		if (wr)
		begin
			case (l_q.wr_cmd)
				spr_pkg::OFS_CONV_SETUP:
				begin
					rail = l_q.wr_dat[2:0];
					c_d.setup[4:0] = l_q.wr_dat[4:0] & spr_pkg::SETUP_WR_MASK;
					if (rail != spr_pkg::RAIL_NONE && rail <= spr_pkg::RAIL_MAX)
					begin
						c_d.setup[spr_pkg::SETUP_BUSY_BIT] = 1'b1;
						c_d.start = 1'b1;
					end
				end
				spr_pkg::OFS_SLOT_A_CTRL: c_d.en[1:0] = l_q.wr_dat[1:0];
				spr_pkg::OFS_SLOT_B_CTRL: c_d.en[3:2] = l_q.wr_dat[1:0];
				spr_pkg::OFS_SLOT_A_COND:
					c_d.fault[4:0] = (c_q.fault[4:0] & ~l_q.wr_dat[4:0]) | fault_event[4:0];
				spr_pkg::OFS_SLOT_B_COND:
					c_d.fault[9:5] = (c_q.fault[9:5] & ~l_q.wr_dat[4:0]) | fault_event[9:5];
				default: ;
			endcase
		end
		for (int i = 0; i < 7; i++)
			c_d.snap[i] = reg_image(c_q, 8'(i));
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			c_q.str_done <= 1'b0;
			c_q.straps   <= 3'h0;
			c_q.tgl_s    <= 2'h0;
			c_q.tgl_seen <= 1'b0;
			c_q.setup    <= spr_pkg::RST_SETUP;
			c_q.result   <= 8'h00;
			c_q.en       <= 4'h0;
			c_q.fault    <= 10'h000;
			c_q.start    <= 1'b0;
			c_q.str_cnt  <= 2'h0;
			c_q.pg_s1    <= 4'h0;
			c_q.pg_s2    <= 4'h0;
			c_q.sh_s1    <= 8'h00;
			c_q.sh_s2    <= 8'h00;
			for (int i = 0; i < 7; i++)
				c_q.snap[i] <= 8'h00;
		end
		else
			c_q <= c_d;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			strap_s1 <= 3'h0;
			strap_s2 <= 3'h0;
		end
		else
		begin
			strap_s1 <= {addr_strap_hi, addr_strap_mid, addr_strap_lo};
			strap_s2 <= strap_s1;
		end
	end

	assign conv_start   = c_q.start;
	assign conv_select  = c_q.setup[4:0];
	assign slot_enable  = c_q.en;
	assign int_n        = 1'b1;

	// Link domain: register images and strap bits cross as quasi-static words
	always_ff @(posedge smb_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < 7; i++)
			begin
				img_s1[i] <= 8'h00;
				img_s2[i] <= 8'h00;
			end
			sda_r <= 1'b1;
		end
		else
		begin
			for (int i = 0; i < 7; i++)
			begin
				img_s1[i] <= c_q.snap[i];
				img_s2[i] <= img_s1[i];
			end
			sda_r <= smb_data_in;
		end
	end

	// A data fall while the link clock is high is a start; data only moves while the clock
	// is low, so nothing else flips this toggle, and a start right after a stop is caught too
	always_ff @(negedge smb_data_in or negedge nrst)
	begin
		if (!nrst)
			sta_tgl <= 1'b0;
		else if (smb_clk)
			sta_tgl <= ~sta_tgl;
	end

	// Frame state moves on falling link edges, so the data driver changes only while clock is low
	always_comb
	begin
		logic [7:0] b;
		b = {l_q.shf[6:0], sda_r};
		l_d = l_q;
		l_d.sta_seen = sta_tgl;
		l_d.bcnt = l_q.bcnt + 3'h1;
		l_d.oe = 1'b0;
		case (l_q.st)
			LS_IDLE: l_d.bcnt = 3'h0;
			LS_ADDR, LS_CMD, LS_DATA:
			begin
				l_d.shf = b;
				if (l_q.bcnt == 3'h7)
				begin
					l_d.st = LS_ACK;
					l_d.oe = 1'b1;
					if (l_q.st == LS_ADDR)
					begin
						l_d.rd = b[0];
						l_d.phase = 2'h0;
						if (b[7:1] != {spr_pkg::ADDR_HI_BITS, c_q.straps})
						begin
							l_d.st = LS_IDLE;
							l_d.oe = 1'b0;
						end
					end
					else if (l_q.st == LS_CMD)
					begin
						l_d.cmd = b;
						l_d.phase = 2'h1;
					end
					else
					begin
						l_d.wr_cmd = l_q.cmd;
						l_d.wr_dat = b;
						l_d.wr_tgl = ~l_q.wr_tgl;
						l_d.phase = 2'h2;
					end
				end
			end
			LS_ACK:
			begin
				l_d.bcnt = 3'h0;
				if (l_q.rd)
				begin
					l_d.st = LS_RD;
					l_d.shf = (l_q.cmd <= spr_pkg::OFS_SHARED_COND) ? img_s2[l_q.cmd[2:0]] : 8'h00;
					l_d.oe = !l_d.shf[7];
				end
				else if (l_q.phase == 2'h0)
					l_d.st = LS_CMD;
				else if (l_q.phase == 2'h1)
					l_d.st = LS_DATA;
				else
					l_d.st = LS_IDLE;
			end
			LS_RD:
			begin
				l_d.shf = {l_q.shf[6:0], 1'b0};
				l_d.oe = !l_q.shf[6];
				if (l_q.bcnt == 3'h7)
				begin
					l_d.oe = 1'b0;
					l_d.st = LS_RACK;
				end
			end
			LS_RACK: l_d.st = LS_IDLE;
			default: l_d.st = LS_IDLE;
		endcase
		if (sta_tgl != l_q.sta_seen)
		begin
			l_d.st = LS_ADDR;
			l_d.bcnt = 3'h0;
			l_d.oe = 1'b0;
		end
	end

	always_ff @(negedge smb_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			l_q <= '0;
		end
		else
			l_q <= l_d;
	end

	assign smb_data_oe  = l_q.oe;
	assign smb_data_out = 1'b0;

	AST_SETUP_RSV_ZERO: assert property (@(posedge clk) disable iff (!nrst)
		c_q.snap[1][6:5] == 2'h0) else $error("Reserved setup bits not zero");
	AST_BUSY_CLEARS: assert property (@(posedge clk) disable iff (!nrst)
		conv_done && c_q.setup[7] |=> !c_q.setup[7] && c_q.result == $past(conv_data))
		else $error("Busy did not clear with result");
	AST_START_BUSY: assert property (@(posedge clk) disable iff (!nrst)
		c_q.start |-> c_q.setup[7] && c_q.setup[2:0] != 3'h0)
		else $error("Start without busy");
	AST_CTRL_RSV: assert property (@(posedge clk) disable iff (!nrst)
		c_q.snap[2][5:2] == 4'h0 && c_q.snap[3][5:2] == 4'h0)
		else $error("Control reserved bits not zero");
	AST_FAULT_STICKY: assert property (@(posedge clk) disable iff (!nrst)
		fault_event[0] |=> c_q.fault[0]) else $error("Fault event lost");
	AST_STRAP_ONCE: assert property (@(posedge clk) disable iff (!nrst)
		c_q.str_done |=> $stable(c_q.straps)) else $error("Straps relatched");
endmodule
`default_nettype wire

//--- tb/spr_host.sv
// SMBus host model issuing byte reads and byte writes
`default_nettype none
module spr_host
(
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Data moves only while clock is low except at start and stop; clock idles high between frames
	task automatic bit_io(input logic b, output logic r);
		sda_low = !b;
		#31.25 scl = 1'b1;
		#62.5 r = sda;
		scl = 1'b0;
		#31.25;
	endtask
	task automatic start();
		sda_low = 1'b0;
		#31.25 scl = 1'b1;
		#62.5 sda_low = 1'b1;
		#62.5 scl = 1'b0;
		#31.25;
	endtask
	task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic a);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(1'b1, a);
	endtask
	task automatic xfer(input logic rd, input logic [6:0] sa, input logic [7:0] cmd, wd,
		output logic [7:0] rdat, output logic ack);
		logic [7:0] x;
		logic       a1;
		logic       a2;
		logic       a3;
		start();
		byte_io({sa, 1'b0}, x, a1);
		byte_io(cmd, x, a2);
		if (rd)
		begin
			start();
			byte_io({sa, 1'b1}, x, a3);
			byte_io(8'hff, rdat, x[0]);
		end
		else
			byte_io(wd, x, a3);
		sda_low = 1'b1;
		#31.25 scl = 1'b1;
		#62.5 sda_low = 1'b0;
		#62.5 ack = a1 | a2 | a3;
	endtask
endmodule
`default_nettype wire

//--- tb/slot_power_register_map_bench.sv
// Testbench of the slot power register map driven by an SMBus host model
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end
module slot_power_register_map_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk, nrst, scl, h_low, oe, c_start, c_done;
	logic [4:0] c_sel;
	logic [7:0] c_data, sh_st, rd;
	logic [3:0] pg, en;
	logic [9:0] flt;
	logic [2:0] strap;
	logic       ack;
	int         bad_count, n_checks, n_start;
	wire logic  sda = !(h_low || oe);
	spr_host host (.scl(scl), .sda_low(h_low), .sda(sda));
	spr_regs uut (.clk(clk), .nrst(nrst), .smb_clk(scl), .smb_data_in(sda),
		.smb_data_out(), .smb_data_oe(oe), .addr_strap_hi(strap[2]),
		.addr_strap_mid(strap[1]), .addr_strap_lo(strap[0]), .conv_start(c_start),
		.conv_select(c_sel), .conv_done(c_done), .conv_data(c_data), .power_good(pg),
		.fault_event(flt), .shared_status(sh_st), .slot_enable(en), .int_n());
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Slow converter so a read right after the setup write still sees busy
	always @(posedge clk)
		if (c_start === 1'b1)
		begin
			n_start++;
			repeat (4000) @(negedge clk);
			c_data <= {3'h0, c_sel} ^ 8'ha5;
			c_done <= 1'b1;
			@(negedge clk) c_done <= 1'b0;
		end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic rw(input logic r, input logic [7:0] cmd, wd);
		host.xfer(r, {4'h8, strap}, cmd, wd, rd, ack);
		repeat (10) @(negedge clk);
	endtask
	task automatic t_reset();
		rw(1, 8'h01, 0); `CHK("setup", 8'h00, rd)
		rw(1, 8'h02, 0); `CHK("ctrl_a", 8'h40, rd)
		rw(1, 8'h03, 0); `CHK("ctrl_b", 8'h80, rd)
		`CHK("enables", 4'h0, en)
		rw(1, 8'h07, 0); `CHK("unmapped", 8'h00, rd)
		`CHK("ack", 1'b0, ack)
		$display("t_reset done");
	endtask
	task automatic t_ctrl();
		rw(0, 8'h02, 8'hff); rw(1, 8'h02, 0); `CHK("ctrl_a", 8'h43, rd)
		rw(0, 8'h03, 8'h02); rw(1, 8'h03, 0); `CHK("ctrl_b", 8'h82, rd)
		`CHK("enables", 4'hb, en)
		rw(0, 8'h02, 8'h00); `CHK("enables", 4'h8, en)
		$display("t_ctrl done");
	endtask
	task automatic t_conv();
		logic [7:0] w;
		int         k;
		for (int r = 0; r < 6; r++)
		begin
			w = {3'h7, r[0], r[1], r[2:0]};
			k = n_start;
			rw(0, 8'h01, w); rw(1, 8'h01, 0);
			`CHK("busy", {(r != 0), 2'b00, w[4:0]}, rd)
			`CHK("starts", k + (r != 0), n_start)
			`CHK("select", w[4:0], c_sel)
			// Poll busy instead of waiting the long fixed time
			for (k = 0; k < 20 && rd[7] !== 1'b0; k++)
				rw(1, 8'h01, 0);
			if (k == 20)
			begin
				bad_count++;
				end_of_test();
			end
			if (r != 0)
			begin
				rw(1, 8'h00, 0); `CHK("result", {3'h0, w[4:0]} ^ 8'ha5, rd)
			end
		end
		$display("t_conv done");
	endtask
	task automatic t_fault();
		@(negedge clk) flt = 10'h001;
		@(negedge clk) flt = 10'h000;
		rw(1, 8'h04, 0); `CHK("fault_set", 5'h01, rd[4:0])
		rw(0, 8'h04, 8'h01); rw(1, 8'h04, 0); `CHK("fault_clr", 5'h00, rd[4:0])
		rw(1, 8'h06, 0); `CHK("shared", sh_st, rd)
		host.xfer(0, {4'h8, ~strap}, 8'h02, 8'h03, rd, ack);
		`CHK("nack", 1'b1, ack)
		rw(1, 8'h02, 0); `CHK("ctrl_a", 8'h40, rd)
		$display("t_fault done");
	endtask
	initial
	begin
		nrst = 1'b0;
		c_done = 1'b0;
		c_data = 8'h00;
		pg = 4'h6;
		flt = 10'h000;
		sh_st = 8'h5a;
		strap = 3'h5;
		bad_count = 0;
		n_checks = 0;
		n_start = 0;
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		t_reset();
		t_ctrl();
		t_conv();
		t_fault();
		end_of_test();
	end
endmodule
`default_nettype wire
